// ==== bcs_slave.sv ====
// calibrator serial slave: address, read back, write code, commit
// What the link does, on the master side and in this block
// - master starts only on idle bus
// - start is sda falling while scl high
// - stop is sda rising while scl high
// - master wraps commands in start, stop
// - data changes only while clock low
// - one data bit per clock pulse
// - two bytes per transaction
// - first byte: device code plus direction
// - ack address only on match, not busy
// - read returns code then zero bit
// - write code with trailing one loads it
// - trailing zero byte commits code
// - low programming supply refuses commit
// - ack each accepted byte on ninth pulse
// - master nacks read, slave releases line
// - busy commit nacks address
// - commit refused unless code written since last commit
`timescale 1ns/1ps
module bcs_slave #(
   parameter int COMMIT_CYCLES = bcs_pkg::COMMIT_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   bcs_if.slave bus,
   input wire logic programming_high_voltage_input,
   input wire logic [6:0] nv_code,
   output logic [6:0] cal_code,
   output logic [6:0] nv_write_data,
   output logic nv_write,
   output logic commit_busy,
   output logic ready
);
   typedef enum logic [2:0] {
      BCS_LOAD = 3'b000, BCS_IDLE = 3'b001, BCS_ADDR = 3'b011, BCS_AACK = 3'b010,
      BCS_RX = 3'b110, BCS_TX = 3'b111, BCS_DACK = 3'b101, BCS_WAIT = 3'b100
   } bcs_state_e;

   logic start_seen;
   logic stop_seen;
   logic scl_rise;
   logic scl_fall;
   bcs_cond_det bcs_cond_det_inst (
      .clk(clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
      .start_seen(start_seen), .stop_seen(stop_seen), .scl_rise(scl_rise), .scl_fall(scl_fall)
   );

   bcs_state_e state, next_state;
   logic [7:0] shreg, next_shreg;
   logic [3:0] bitcnt, next_bitcnt;
   logic [6:0] next_cal_code;
   logic dirty, next_dirty;
   logic [15:0] cnt, next_cnt;
   logic sda_low, next_sda_low;
   logic rd, next_rd;
   logic [6:0] next_nv_write_data;
   logic next_nv_write;
   logic next_busy;
   logic next_ready;

   always_comb
   begin
      next_state = state;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_cal_code = cal_code;
      next_dirty = dirty;
      next_cnt = cnt;
      next_sda_low = sda_low;
      next_rd = rd;
      next_nv_write_data = nv_write_data;
      next_nv_write = 1'b0;
      next_busy = commit_busy;
      next_ready = ready;
      // commit timer runs independently of the bus
      if (commit_busy)
      begin
         if (cnt == 16'(COMMIT_CYCLES - 1))
         begin
            next_busy = 1'b0;
            next_cnt = bcs_pkg::CNT_RESET;
         end
         else
            next_cnt = cnt + 16'h0001;
      end
      unique case (state)
         BCS_LOAD:
         begin
            if (cnt == 16'(bcs_pkg::LOAD_CYCLES - 1))
            begin
               next_cal_code = nv_code;
               next_cnt = bcs_pkg::CNT_RESET;
               next_ready = 1'b1;
               next_state = BCS_IDLE;
            end
            else
               next_cnt = cnt + 16'h0001;
         end
         BCS_IDLE: ;
         BCS_ADDR, BCS_RX:
         begin
            if (scl_rise)
            begin
               next_shreg = {shreg[6:0], bus.sda};
               next_bitcnt = bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'(bcs_pkg::BITS_PER_BYTE))
            begin
               next_bitcnt = bcs_pkg::BIT_RESET;
               if (state == BCS_ADDR)
               begin
                  if (shreg[7:1] == bcs_pkg::DEV_ADDR && !commit_busy)
                  begin
                     next_sda_low = 1'b1;
                     next_rd = shreg[0];
                     next_state = BCS_AACK;
                  end
                  else
                     next_state = BCS_WAIT;
               end
               else if (shreg[0])
               begin
                  next_cal_code = shreg[7:1];
                  next_dirty = 1'b1;
                  next_sda_low = 1'b1;
                  next_state = BCS_DACK;
               end
               else if (programming_high_voltage_input && dirty)
               begin
                  next_nv_write_data = cal_code;
                  next_nv_write = 1'b1;
                  next_busy = 1'b1;
                  next_cnt = bcs_pkg::CNT_RESET;
                  next_dirty = 1'b0;
                  next_sda_low = 1'b1;
                  next_state = BCS_DACK;
               end
               else
                  next_state = BCS_WAIT;
            end
         end
         BCS_AACK:
         begin
            if (scl_fall)
            begin
               next_bitcnt = bcs_pkg::BIT_RESET;
               if (rd)
               begin
                  next_shreg = {cal_code, 1'b0};
                  next_sda_low = ~cal_code[6];
                  next_state = BCS_TX;
               end
               else
               begin
                  next_sda_low = 1'b0;
                  next_state = BCS_RX;
               end
            end
         end
         BCS_TX:
         begin
            if (scl_fall)
            begin
               next_bitcnt = bitcnt + 4'h1;
               next_shreg = {shreg[6:0], 1'b0};
               if (bitcnt == 4'(bcs_pkg::BITS_PER_BYTE - 1))
               begin
                  next_sda_low = 1'b0;
                  next_state = BCS_WAIT;
               end
               else
                  next_sda_low = ~shreg[6];
            end
         end
         BCS_DACK:
         begin
            if (scl_fall)
            begin
               next_sda_low = 1'b0;
               next_state = BCS_WAIT;
            end
         end
         BCS_WAIT: ;
      endcase
      if (state != BCS_LOAD)
      begin
         if (start_seen)
         begin
            next_sda_low = 1'b0;
            next_bitcnt = bcs_pkg::BIT_RESET;
            next_state = (state == BCS_IDLE) ? BCS_ADDR : BCS_WAIT;
         end
         else if (stop_seen)
         begin
            next_sda_low = 1'b0;
            next_state = BCS_IDLE;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= BCS_LOAD;
         shreg <= bcs_pkg::BYTE_RESET;
         bitcnt <= bcs_pkg::BIT_RESET;
         cal_code <= bcs_pkg::CODE_RESET;
         dirty <= 1'b0;
         cnt <= bcs_pkg::CNT_RESET;
         sda_low <= 1'b0;
         rd <= 1'b0;
         nv_write_data <= bcs_pkg::CODE_RESET;
         nv_write <= 1'b0;
         commit_busy <= 1'b0;
         ready <= 1'b0;
      end
      else
      begin
         state <= next_state;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         cal_code <= next_cal_code;
         dirty <= next_dirty;
         cnt <= next_cnt;
         sda_low <= next_sda_low;
         rd <= next_rd;
         nv_write_data <= next_nv_write_data;
         nv_write <= next_nv_write;
         commit_busy <= next_busy;
         ready <= next_ready;
      end
   end

   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe_n = ~sda_low;
endmodule // bcs_slave

// ==== bcs_pkg.sv ====
// shared constants for the calibrator serial link
package bcs_pkg;
   localparam int CODE_W = 7;
   localparam int ADDR_W = 7;
   // device code is arbitrary, not a real part's value
   localparam logic [6:0] DEV_ADDR = 7'h2A;
   localparam logic [6:0] CODE_RESET = 7'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] BIT_RESET = 4'h0;
   localparam int BITS_PER_BYTE = 8;
   // nonvolatile commit time in ns, and cycles at 40 MHz
   localparam int CLK_PERIOD_NS = 25;
   localparam int COMMIT_TIME_NS = 100000;
   localparam int COMMIT_CYCLES = (COMMIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // power-up load time in ns
   localparam int LOAD_TIME_NS = 1000;
   localparam int LOAD_CYCLES = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // master bit clock: quarter-period in clk cycles
   localparam int QTR_CYCLES = 25;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

// ==== bcs_if.sv ====
// two-wire link between programming master and calibrator
`timescale 1ns/1ps
interface bcs_if;
   logic scl_o;
   logic scl_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_s_o;
   logic sda_s_oe_n;
   logic scl;
   logic sda;
   // open drain with pull-up: low when any enabled driver is low
   assign scl = scl_oe_n ? 1'b1 : scl_o;
   assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);
   modport master (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n, input scl, input sda);
   modport slave (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface

// ==== bcs_cond_det.sv ====
// start and stop condition detector on the two-wire pins
`timescale 1ns/1ps
module bcs_cond_det
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   output logic start_seen,
   output logic stop_seen,
   output logic scl_rise,
   output logic scl_fall
);
   logic scl_d;
   logic sda_d;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end
   assign start_seen = scl & scl_d & sda_d & ~sda;
   assign stop_seen = scl & scl_d & ~sda_d & sda;
   assign scl_rise = scl & ~scl_d;
   assign scl_fall = ~scl & scl_d;
endmodule // bcs_cond_det

// ==== bcs_master.sv ====
// programming master: one two-byte transaction per request
`timescale 1ns/1ps
module bcs_master
(
   input wire logic clk,
   input wire logic rst,
   bcs_if.master bus,
   input wire logic req,
   input wire logic req_read,
   input wire logic [7:0] req_data,
   output logic busy,
   output logic done,
   output logic [7:0] rd_data,
   output logic addr_ack,
   output logic data_ack
);
   typedef enum logic [2:0] {
      BCM_IDLE = 3'b000, BCM_START = 3'b001, BCM_BIT = 3'b011, BCM_STOP = 3'b010, BCM_DONE = 3'b110
   } bcm_state_e;

   bcm_state_e state, next_state;
   logic [15:0] qcnt, next_qcnt;
   logic [1:0] phase, next_phase;
   logic [4:0] bitn, next_bitn;
   logic [17:0] tx, next_tx;
   logic rdop, next_rdop;
   logic scl_low, next_scl_low;
   logic sda_low, next_sda_low;
   logic [7:0] next_rd_data;
   logic next_addr_ack, next_data_ack, next_busy, next_done;
   logic tick;

   assign tick = (qcnt == 16'(bcs_pkg::QTR_CYCLES - 1));

   always_comb
   begin
      next_state = state;
      next_qcnt = tick ? bcs_pkg::CNT_RESET : qcnt + 16'h0001;
      next_phase = phase;
      next_bitn = bitn;
      next_tx = tx;
      next_rdop = rdop;
      next_scl_low = scl_low;
      next_sda_low = sda_low;
      next_rd_data = rd_data;
      next_addr_ack = addr_ack;
      next_data_ack = data_ack;
      next_busy = busy;
      next_done = 1'b0;
      unique case (state)
         BCM_IDLE:
         begin
            if (req && bus.scl && bus.sda)
            begin
               // bits: address, ack slot, data, ack slot
               next_tx = {bcs_pkg::DEV_ADDR, req_read, 1'b1, req_read ? 8'hFF : req_data, 1'b1};
               next_rdop = req_read;
               next_busy = 1'b1;
               next_phase = 2'h0;
               next_qcnt = bcs_pkg::CNT_RESET;
               next_state = BCM_START;
            end
         end
         BCM_START:
         begin
            if (tick)
            begin
               next_phase = phase + 2'h1;
               if (phase == 2'h0)
                  next_sda_low = 1'b1;
               else if (phase == 2'h1)
               begin
                  next_scl_low = 1'b1;
                  next_bitn = 5'h00;
                  next_phase = 2'h0;
                  next_state = BCM_BIT;
               end
            end
         end
         BCM_BIT:
         begin
            if (tick)
            begin
               next_phase = phase + 2'h1;
               unique case (phase)
                  2'h0: next_sda_low = ~tx[17];
                  2'h1: next_scl_low = 1'b0;
                  2'h2:
                  begin
                     if (bitn == 5'h08)
                        next_addr_ack = ~bus.sda;
                     else if (bitn == 5'h11)
                        next_data_ack = ~bus.sda;
                     else if (bitn > 5'h08)
                        next_rd_data = {rd_data[6:0], bus.sda};
                  end
                  2'h3:
                  begin
                     next_scl_low = 1'b1;
                     next_tx = {tx[16:0], 1'b1};
                     next_bitn = bitn + 5'h01;
                     // nack on address ends early
                     if (bitn == 5'h11 || (bitn == 5'h08 && !addr_ack))
                        next_state = BCM_STOP;
                  end
               endcase
            end
         end
         BCM_STOP:
         begin
            if (tick)
            begin
               next_phase = phase + 2'h1;
               if (phase == 2'h0)
                  next_sda_low = 1'b1;
               else if (phase == 2'h1)
                  next_scl_low = 1'b0;
               else if (phase == 2'h2)
               begin
                  next_sda_low = 1'b0;
                  next_state = BCM_DONE;
               end
            end
         end
         BCM_DONE:
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = BCM_IDLE;
         end
         default: next_state = BCM_IDLE;
      endcase
      // read data byte: release line, nack the last byte
      if (rdop && state == BCM_BIT && phase == 2'h0 && tick && bitn > 5'h08)
         next_sda_low = 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= BCM_IDLE;
         qcnt <= bcs_pkg::CNT_RESET;
         phase <= 2'h0;
         bitn <= 5'h00;
         tx <= 18'h3FFFF;
         rdop <= 1'b0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         rd_data <= bcs_pkg::BYTE_RESET;
         addr_ack <= 1'b0;
         data_ack <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         qcnt <= next_qcnt;
         phase <= next_phase;
         bitn <= next_bitn;
         tx <= next_tx;
         rdop <= next_rdop;
         scl_low <= next_scl_low;
         sda_low <= next_sda_low;
         rd_data <= next_rd_data;
         addr_ack <= next_addr_ack;
         data_ack <= next_data_ack;
         busy <= next_busy;
         done <= next_done;
      end
   end

   assign bus.scl_o = 1'b0;
   assign bus.scl_oe_n = ~scl_low;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe_n = ~sda_low;
endmodule // bcs_master

// ==== bcs_link_props.sv ====
// concurrent checks on the two-wire link between master and calibrator
`timescale 1ns/1ps
module bcs_link_props
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_o,
   input wire logic scl_oe_n,
   input wire logic sda_m_o,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_o,
   input wire logic sda_s_oe_n,
   input wire logic scl,
   input wire logic sda
);
   localparam int MAX_DRIVE = 1000;
   logic [10:0] drive_len;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // length of one unbroken slave drive, ack plus a full byte of zeros at most
   always_ff @(posedge clk or posedge rst)
      if (rst)
         drive_len <= 11'h000;
      else if (!sda_s_oe_n)
         drive_len <= drive_len + 11'h001;
      else
         drive_len <= 11'h000;

   chk_slave_pull_low: assert property ($rose(scl) && !sda_s_oe_n |-> (!sda_s_oe_n && !sda_s_o) [*8])
      else $error("slave let go of data line during clock high");
   chk_slave_drive_low: assert property ($fell(sda_s_oe_n) |-> !scl)
      else $error("slave took data line while clock high");
   chk_slave_release_low: assert property ($rose(sda_s_oe_n) |-> !scl)
      else $error("slave released data line while clock high");
   chk_slave_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe_n))
      else $error("slave data changed during clock high");
   chk_drive_bounded: assert property (drive_len < MAX_DRIVE)
      else $error("slave holds data line too long");
   chk_start_hold: assert property ($fell(sda) && scl |-> (scl && !sda) [*4])
      else $error("start condition not held");
   chk_stop_idle: assert property ($rose(sda) && scl |-> (scl && sda) [*4])
      else $error("bus not idle after stop");
   chk_clock_high: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   chk_master_hold_data: assert property ($rose(scl) && !sda_m_oe_n |-> (!sda_m_oe_n && scl_oe_n && !(sda_m_o | scl_o)) [*8])
      else $error("master changed data line during clock high");

   cover property ($fell(sda_s_oe_n) ##[1:200] scl);
   cover property ($fell(sda) && scl);
   cover property (drive_len == 11'h320);
endmodule // bcs_link_props

// ==== test_backplane_calibrator_serial_slave.sv ====
// self-checking bench: master and calibrator joined over the link
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_backplane_calibrator_serial_slave;
   localparam int COMMIT_SHORT = 1500;
   localparam int CYCLE_LIMIT = 60000;
   typedef struct {
      logic rd;
      logic aack;
      logic dack;
      logic [7:0] rdv;
      logic [6:0] code;
      int nvw;
   } bcs_note_s;
   logic clk, rst, req, req_read, busy, done, addr_ack, data_ack;
   logic [7:0] req_data, rd_data;
   logic programming_high_voltage_input, nv_write, commit_busy, ready;
   logic [6:0] nv_code, cal_code, nv_write_data, m_code, c;
   logic m_dirty;
   int mismatches = 0;
   int n_checks = 0;
   int m_nvw, n_nvw, cyc, n, i;
   bcs_note_s notes[$];
   bcs_note_s note;

   bcs_if bcs_if_inst();
   bcs_master bcs_master_inst(.clk(clk), .rst(rst), .bus(bcs_if_inst.master), .req(req), .req_read(req_read),
      .req_data(req_data), .busy(busy), .done(done), .rd_data(rd_data), .addr_ack(addr_ack), .data_ack(data_ack));
   bcs_slave #(.COMMIT_CYCLES(COMMIT_SHORT)) bcs_slave_inst(.clk(clk), .rst(rst), .bus(bcs_if_inst.slave),
      .programming_high_voltage_input(programming_high_voltage_input), .nv_code(nv_code), .cal_code(cal_code),
      .nv_write_data(nv_write_data), .nv_write(nv_write), .commit_busy(commit_busy), .ready(ready));
   bcs_link_props bcs_link_props_inst(.clk(clk), .rst(rst), .scl_o(bcs_if_inst.scl_o),
      .scl_oe_n(bcs_if_inst.scl_oe_n), .sda_m_o(bcs_if_inst.sda_m_o), .sda_m_oe_n(bcs_if_inst.sda_m_oe_n),
      .sda_s_o(bcs_if_inst.sda_s_o), .sda_s_oe_n(bcs_if_inst.sda_s_oe_n), .scl(bcs_if_inst.scl),
      .sda(bcs_if_inst.sda));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // one two-byte transaction; expectation noted before the request
   task automatic xfer(input logic rd, input logic [7:0] d, input logic aack);
      bcs_note_s nt;
      int k;
      @(posedge clk);
      nt.dack = 1'b1;
      if (aack && !rd && d[0])
      begin
         m_code = d[7:1];
         m_dirty = 1'b1;
      end
      else if (aack && !rd)
      begin
         nt.dack = programming_high_voltage_input & m_dirty;
         m_nvw += int'(nt.dack);
         m_dirty = m_dirty & ~nt.dack;
      end
      nt.rd = rd;
      nt.aack = aack;
      nt.rdv = {m_code, 1'b0};
      nt.code = m_code;
      nt.nvw = m_nvw;
      notes.push_back(nt);
      req <= 1'b1;
      req_read <= rd;
      req_data <= d;
      @(posedge clk);
      req <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 5000)
      begin
         @(negedge clk);
         k++;
      end
      if (k == 5000)
         mismatches++;
      repeat (8) @(posedge clk);
   endtask

   // result monitor: oldest note against each finished transaction
   always @(posedge clk)
   begin
      if (done === 1'b1)
      begin
         note = notes.pop_front();
         `CHK(addr_ack, note.aack)
         `CHK(busy, 1'b0)
         if (note.aack && note.rd)
            `CHK(rd_data, note.rdv)
         else if (note.aack)
            `CHK(data_ack, note.dack)
         `CHK(cal_code, note.code)
         `CHK(n_nvw, note.nvw)
      end
      if (nv_write === 1'b1)
      begin
         n_nvw++;
         `CHK(commit_busy, 1'b1)
         `CHK(nv_write_data, m_code)
      end
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == CYCLE_LIMIT)
      begin
         mismatches++;
         results();
      end
   end

   initial
   begin
      void'($urandom(32'hDB9C1051));
      rst = 1'b1;
      req = 1'b0;
      req_read = 1'b0;
      req_data = 8'h00;
      programming_high_voltage_input = 1'b1;
      nv_code = 7'($urandom);
      m_nvw = 0;
      n_nvw = 0;
      cyc = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      m_code = nv_code;
      m_dirty = 1'b0;
      @(negedge clk);
      `CHK(ready, 1'b0)
      n = 0;
      while (ready !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(n, bcs_pkg::LOAD_CYCLES)
      xfer(1'b1, 8'h00, 1'b1);
      xfer(1'b0, {7'($urandom), 1'b0}, 1'b1);
      for (i = 0; i < 4; i++)
      begin
         c = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
         xfer(1'b0, {c, 1'b1}, 1'b1);
         xfer(1'b1, 8'h00, 1'b1);
      end
      programming_high_voltage_input <= 1'b0;
      xfer(1'b0, {7'($urandom), 1'b0}, 1'b1);
      programming_high_voltage_input <= 1'b1;
      xfer(1'b0, {7'($urandom), 1'b0}, 1'b1);
      xfer(1'b1, 8'h00, 1'b0);
      n = 0;
      while (commit_busy !== 1'b0 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(commit_busy, 1'b0)
      xfer(1'b1, 8'h00, 1'b1);
      xfer(1'b0, {7'($urandom), 1'b0}, 1'b1);
      results();
   end
endmodule // test_backplane_calibrator_serial_slave
